// ===== hdl/torque_shutoff_pkg.sv
// Package: constants and carrier types for the safe torque off control block.
// Assumes a single core clock at 100 MHz and synchronous active-low reset.
package torque_shutoff_pkg;

    localparam int unsigned CLK_MHZ          = 100;
    // Off pulses shorter than this are treated as self-test pulses
    localparam int unsigned FILTER_MIN_US    = 1000;
    localparam int unsigned FILTER_CYCLES    = FILTER_MIN_US * CLK_MHZ;
    // Torque must be gone within this time of a shutoff request
    localparam int unsigned RESPONSE_MAX_US  = 5000;
    localparam int unsigned RESPONSE_CYCLES  = RESPONSE_MAX_US * CLK_MHZ;
    // Disagreement between channels longer than this is a fault
    localparam int unsigned DISCREP_MAX_US   = 5000;
    localparam int unsigned DISCREP_CYCLES   = DISCREP_MAX_US * CLK_MHZ;

    // Front panel codes, two ASCII characters
    localparam logic [15:0] SAFETY_STATE_DISPLAY_CODE = 16'h5374;
    localparam logic [15:0] DISPLAY_BLANK             = 16'h2020;
    localparam logic [15:0] DISPLAY_FAULT_CODE        = 16'h3331;

    // Alarm sub-codes for safety faults
    localparam logic [3:0] FAULT_SUB_NONE   = 4'h0;
    localparam logic [3:0] FAULT_SUB_INPUT  = 4'h0;
    localparam logic [3:0] FAULT_SUB_DRIVE  = 4'h2;

    // Alarm stop sequence: dynamic brake choice during shutoff
    localparam logic [1:0] STOP_SEQ_FREE_RUN = 2'h0;

    typedef enum {ST_SERVO_OFF, ST_SERVO_ON, ST_SAFETY} drive_state_t;

    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } gate_drive_t;

    typedef struct packed {
        logic       active;
        logic [3:0] sub_code;
    } safety_alarm_t;

endpackage

// ===== hdl/safety_input_filter.sv
// Filter for one safety input channel: two-stage synchroniser then off filter.
// Assumes the raw input is asynchronous to core_clk; high means current flows.
`timescale 1ns/1ps
`default_nettype none
module safety_input_filter #(
    parameter int unsigned FILTER_CYCLES = torque_shutoff_pkg::FILTER_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic raw_in,
    output logic      shutoff_req
);
    localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);

    if (FILTER_CYCLES < 1) begin : g_bad_filter
        $error("FILTER_CYCLES must be at least 1");
    end

    logic          sync1_reg;
    logic          sync2_reg;
    logic [CW-1:0] off_cnt_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Off must persist the whole window; any on sample restarts it.
    // Reset starts in shutoff so power-up never releases torque early.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            off_cnt_reg <= '0;
            shutoff_req <= 1'b1;
        end else if (sync2_reg) begin
            off_cnt_reg <= '0;
            shutoff_req <= 1'b0;
        end else if (off_cnt_reg == CW'(FILTER_CYCLES)) begin
            shutoff_req <= 1'b1;
        end else begin
            off_cnt_reg <= off_cnt_reg + CW'(1);
        end
    end
endmodule // safety_input_filter
`default_nettype wire

// ===== hdl/safe_torque_off_control.sv
// Safe torque off control: gates the power stage from two safety inputs.
// Assumes raw safety inputs are asynchronous pins, other inputs are on core_clk.
`timescale 1ns/1ps
`default_nettype none
module safe_torque_off_control #(
    parameter int unsigned FILTER_CYCLES  = torque_shutoff_pkg::FILTER_CYCLES,
    parameter int unsigned DISCREP_CYCLES = torque_shutoff_pkg::DISCREP_CYCLES
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst_b,
    input  wire logic                          safety_in_a,
    input  wire logic                          safety_in_b,
    input  wire logic                          servo_on_cmd,
    input  wire torque_shutoff_pkg::gate_drive_t gate_cmd,
    input  wire logic [1:0]                    alarm_stop_sequence_setting,
    input  wire logic                          alarm_clear,
    output torque_shutoff_pkg::gate_drive_t    gate_out,
    output logic                               servo_ready,
    output logic                               torque_shutoff,
    output logic                               dyn_brake_on,
    output logic [15:0]                        display_code,
    output torque_shutoff_pkg::safety_alarm_t  safety_alarm
);
    localparam int unsigned DW = $clog2(DISCREP_CYCLES + 1);

    // A filter longer than the response budget could never meet it
    if (FILTER_CYCLES + 2 + 1 > torque_shutoff_pkg::RESPONSE_CYCLES) begin : g_bad_filter
        $error("Filter too long to meet the shutoff response time");
    end
    if (DISCREP_CYCLES < 1) begin : g_bad_discrep
        $error("DISCREP_CYCLES must be at least 1");
    end

    localparam int unsigned CHANNELS = 2;

    logic [CHANNELS-1:0] raw_pin;
    logic [CHANNELS-1:0] chan_req;
    logic                req_a;
    logic                req_b;

    assign raw_pin = {safety_in_b, safety_in_a};

    // Index 0 serves input a, index 1 input b
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        safety_input_filter #(
            .FILTER_CYCLES (FILTER_CYCLES)
        ) u_filter (
            .core_clk    (core_clk),
            .rst_b       (rst_b),
            .raw_in      (raw_pin[ch]),
            .shutoff_req (chan_req[ch])
        );
    end

    assign req_a = chan_req[0];
    assign req_b = chan_req[1];

    logic any_req;
    assign any_req = req_a | req_b;

    torque_shutoff_pkg::drive_state_t state_reg;
    torque_shutoff_pkg::drive_state_t state_next;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            torque_shutoff_pkg::ST_SERVO_OFF: begin
                if (any_req) begin
                    state_next = torque_shutoff_pkg::ST_SAFETY;
                end else if (servo_on_cmd) begin
                    state_next = torque_shutoff_pkg::ST_SERVO_ON;
                end
            end
            torque_shutoff_pkg::ST_SERVO_ON: begin
                if (any_req) begin
                    state_next = torque_shutoff_pkg::ST_SAFETY;
                end else if (!servo_on_cmd) begin
                    state_next = torque_shutoff_pkg::ST_SERVO_OFF;
                end
            end
            torque_shutoff_pkg::ST_SAFETY: begin
                // Servo-on held high keeps safety so the motor never restarts by itself
                if (!any_req && !servo_on_cmd) begin
                    state_next = torque_shutoff_pkg::ST_SERVO_OFF;
                end
            end
            default: state_next = torque_shutoff_pkg::ST_SAFETY;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= torque_shutoff_pkg::ST_SAFETY;
        end else begin
            state_reg <= state_next;
        end
    end

    // Gates run only in servo-on; taken from the next state to save a cycle
    logic run_next;
    assign run_next = (state_next == torque_shutoff_pkg::ST_SERVO_ON);

    // Gate blocking is taken straight from each channel as well as from the state,
    // so one channel still cuts its arm even if the other path fails.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gate_out <= '0;
        end else begin
            gate_out.upper <= (req_a || !run_next)
                              ? 3'h0 : gate_cmd.upper;
            gate_out.lower <= (req_b || !run_next)
                              ? 3'h0 : gate_cmd.lower;
        end
    end

    logic                              in_safety_next;
    torque_shutoff_pkg::safety_alarm_t alarm_next;

    assign in_safety_next = (state_next == torque_shutoff_pkg::ST_SAFETY);

    // Ready and display follow the alarm in the very cycle it changes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            servo_ready <= 1'b0;
        end else begin
            servo_ready <= !in_safety_next && !alarm_next.active;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            torque_shutoff <= 1'b1;
        end else begin
            torque_shutoff <= in_safety_next;
        end
    end

    // Servo-off braking is owned elsewhere; only the safety case is driven here
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dyn_brake_on <= 1'b0;
        end else begin
            dyn_brake_on <= in_safety_next && (alarm_stop_sequence_setting
                            != torque_shutoff_pkg::STOP_SEQ_FREE_RUN);
        end
    end

    // Channels disagreeing too long means a broken input path
    logic [DW-1:0] discrep_cnt_reg;
    logic          discrep_fault;
    logic          drive_fault;
    logic          req_a_q_reg;
    logic          req_b_q_reg;

    // Requests one cycle late, lined up with the registered gate drive, so a
    // fresh shutoff is not mistaken for a stuck arm
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            req_a_q_reg <= 1'b1;
            req_b_q_reg <= 1'b1;
        end else begin
            req_a_q_reg <= req_a;
            req_b_q_reg <= req_b;
        end
    end

    assign discrep_fault = (discrep_cnt_reg == DW'(DISCREP_CYCLES));
    // Gate drive seen on an arm whose channel requested shutoff a cycle ago
    assign drive_fault = (req_a_q_reg && gate_out.upper != 3'h0) ||
                         (req_b_q_reg && gate_out.lower != 3'h0);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            discrep_cnt_reg <= '0;
        end else if (req_a == req_b) begin
            discrep_cnt_reg <= '0;
        end else if (!discrep_fault) begin
            discrep_cnt_reg <= discrep_cnt_reg + DW'(1);
        end
    end

    // Alarm comes only from faults; a fault still present beats the clear
    always_comb begin
        alarm_next = safety_alarm;
        if (drive_fault) begin
            alarm_next = '{active: 1'b1,
                           sub_code: torque_shutoff_pkg::FAULT_SUB_DRIVE};
        end else if (discrep_fault) begin
            alarm_next = '{active: 1'b1,
                           sub_code: torque_shutoff_pkg::FAULT_SUB_INPUT};
        end else if (alarm_clear) begin
            alarm_next = '{active: 1'b0,
                           sub_code: torque_shutoff_pkg::FAULT_SUB_NONE};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            safety_alarm <= '0;
        end else begin
            safety_alarm <= alarm_next;
        end
    end

    // Reset enters the safety state, so the panel shows it from the start
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            display_code <= torque_shutoff_pkg::SAFETY_STATE_DISPLAY_CODE;
        end else if (alarm_next.active) begin
            display_code <= torque_shutoff_pkg::DISPLAY_FAULT_CODE;
        end else if (in_safety_next) begin
            display_code <= torque_shutoff_pkg::SAFETY_STATE_DISPLAY_CODE;
        end else begin
            display_code <= torque_shutoff_pkg::DISPLAY_BLANK;
        end
    end
endmodule // safe_torque_off_control
`default_nettype wire

// ===== testbench/safety_switch_model.sv
// External safety switch: one contact for each safety channel.
// Assumes the bench opens and closes contacts off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module safety_switch_model (
    input  wire logic open_a,
    input  wire logic open_b,
    output logic      safety_in_a,
    output logic      safety_in_b
);
    // Open contact stops optocoupler current, which requests shutoff
    assign safety_in_a = !open_a;
    assign safety_in_b = !open_b;
endmodule // safety_switch_model
`default_nettype wire

// ===== testbench/safe_torque_off_control_asserts.sv
// Port checker for the safe torque off control block.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module safe_torque_off_control_asserts #(
    parameter int unsigned FILTER_CYCLES = 8
) (
    input wire logic                              core_clk,
    input wire logic                              rst_b,
    input wire logic                              safety_in_a,
    input wire logic                              safety_in_b,
    input wire logic                              servo_on_cmd,
    input wire torque_shutoff_pkg::gate_drive_t   gate_cmd,
    input wire logic [1:0]                        alarm_stop_sequence_setting,
    input wire logic                              alarm_clear,
    input wire torque_shutoff_pkg::gate_drive_t   gate_out,
    input wire logic                              servo_ready,
    input wire logic                              torque_shutoff,
    input wire logic                              dyn_brake_on,
    input wire logic [15:0]                       display_code,
    input wire torque_shutoff_pkg::safety_alarm_t safety_alarm
);
    int unsigned lo_a, lo_b, hi_a, hi_b;
    // Run lengths of each input level; short runs, so no saturation
    always_ff @(posedge core_clk) begin
        lo_a <= (!rst_b || safety_in_a) ? 0 : lo_a + 1;
        lo_b <= (!rst_b || safety_in_b) ? 0 : lo_b + 1;
        hi_a <= (!rst_b || !safety_in_a) ? 0 : hi_a + 1;
        hi_b <= (!rst_b || !safety_in_b) ? 0 : hi_b + 1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_gate_off; torque_shutoff |-> gate_out == '0; endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate drive in safety state");
    property p_upper; lo_a > FILTER_CYCLES + 4 |-> gate_out.upper == 3'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper arm not blocked");
    property p_lower; lo_b > FILTER_CYCLES + 4 |-> gate_out.lower == 3'h0; endproperty
    a_lower: assert property (p_lower) else $error("lower arm not blocked");
    property p_ready; torque_shutoff |-> !servo_ready; endproperty
    a_ready: assert property (p_ready) else $error("ready during shutoff");
    property p_disp;
        torque_shutoff && !safety_alarm.active
            |-> display_code == torque_shutoff_pkg::SAFETY_STATE_DISPLAY_CODE;
    endproperty
    a_disp: assert property (p_disp) else $error("safety code not shown");
    property p_blank;
        !torque_shutoff && !safety_alarm.active
            |-> display_code == torque_shutoff_pkg::DISPLAY_BLANK;
    endproperty
    a_blank: assert property (p_blank) else $error("display not blank");
    property p_brake;
        !torque_shutoff || $past(alarm_stop_sequence_setting) ==
            torque_shutoff_pkg::STOP_SEQ_FREE_RUN |-> !dyn_brake_on;
    endproperty
    a_brake: assert property (p_brake) else $error("brake in free run");
    property p_return;
        hi_a > 8 && hi_b > 8 && !servo_on_cmd && !$past(servo_on_cmd) |-> ##1 !torque_shutoff;
    endproperty
    a_return: assert property (p_return) else $error("no return to servo off");
    c_enter: cover property ($rose(torque_shutoff));
    c_leave: cover property ($fell(torque_shutoff));
    c_alarm: cover property ($rose(safety_alarm.active));
endmodule // safe_torque_off_control_asserts
bind safe_torque_off_control safe_torque_off_control_asserts #(
    .FILTER_CYCLES(FILTER_CYCLES)) i_safe_torque_off_control_asserts (.*);
`default_nettype wire

// ===== testbench/test_safe_torque_off_control.sv
// Self-checking bench for the safe torque off control block.
// Assumes shortened filter and discrepancy counts for a quick run.
`timescale 1ns/1ps
`default_nettype none
module test_safe_torque_off_control;
    logic                              core_clk, rst_b, open_a, open_b;
    logic                              servo_on_cmd, alarm_clear;
    logic                              safety_in_a, safety_in_b;
    logic                              servo_ready, torque_shutoff, dyn_brake_on;
    logic [1:0]                        stop_seq;
    logic [15:0]                       display_code;
    torque_shutoff_pkg::gate_drive_t   gate_cmd, gate_out;
    torque_shutoff_pkg::safety_alarm_t safety_alarm;
    int                                fail_count, check_count, n;
    safety_switch_model i_safety_switch_model (.open_a(open_a), .open_b(open_b),
        .safety_in_a(safety_in_a), .safety_in_b(safety_in_b));
    safe_torque_off_control #(.FILTER_CYCLES(8), .DISCREP_CYCLES(20))
    i_safe_torque_off_control (.core_clk(core_clk), .rst_b(rst_b),
        .safety_in_a(safety_in_a), .safety_in_b(safety_in_b),
        .servo_on_cmd(servo_on_cmd), .gate_cmd(gate_cmd),
        .alarm_stop_sequence_setting(stop_seq), .alarm_clear(alarm_clear),
        .gate_out(gate_out), .servo_ready(servo_ready),
        .torque_shutoff(torque_shutoff), .dyn_brake_on(dyn_brake_on),
        .display_code(display_code), .safety_alarm(safety_alarm));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int c);
        repeat (c) @(negedge core_clk);
    endtask
    // Bounded wait of 50 cycles, longer than the scaled response time
    task automatic wait_ts(input logic v);
        n = 0;
        while (torque_shutoff !== v && n < 50) begin
            ticks(1);
            n++;
        end
        chk(torque_shutoff, v);
    endtask
    task automatic t_release;
        chk(torque_shutoff, 1'b1);
        chk(display_code, torque_shutoff_pkg::SAFETY_STATE_DISPLAY_CODE);
        wait_ts(1'b0);
        chk(display_code, torque_shutoff_pkg::DISPLAY_BLANK);
        chk(safety_alarm, 5'h00);
        servo_on_cmd = 1'b1;
        gate_cmd = 6'h3f;
        ticks(3);
        chk(servo_ready, 1'b1);
        chk(gate_out, 6'h3f);
    endtask
    task automatic t_glitch;
        open_a = 1'b1;
        ticks(6);
        open_a = 1'b0;
        ticks(10);
        chk(torque_shutoff, 1'b0);
        chk(gate_out, 6'h3f);
    endtask
    task automatic t_stop;
        stop_seq = 2'h1;
        open_a = 1'b1;
        open_b = 1'b1;
        wait_ts(1'b1);
        chk(gate_out, 6'h00);
        chk(servo_ready, 1'b0);
        chk(display_code, torque_shutoff_pkg::SAFETY_STATE_DISPLAY_CODE);
        chk(safety_alarm.active, 1'b0);
        chk(dyn_brake_on, 1'b1);
        stop_seq = torque_shutoff_pkg::STOP_SEQ_FREE_RUN;
        ticks(2);
        chk(dyn_brake_on, 1'b0);
        // Inputs back while servo-on is still held must not leave safety
        open_a = 1'b0;
        open_b = 1'b0;
        ticks(15);
        chk(torque_shutoff, 1'b1);
        servo_on_cmd = 1'b0;
        wait_ts(1'b0);
        chk(safety_alarm.active, 1'b0);
    endtask
    task automatic t_fault;
        open_a = 1'b1;
        n = 0;
        while (safety_alarm.active !== 1'b1 && n < 80) begin
            ticks(1);
            n++;
        end
        chk(safety_alarm, {1'b1, torque_shutoff_pkg::FAULT_SUB_INPUT});
        chk(display_code, torque_shutoff_pkg::DISPLAY_FAULT_CODE);
        open_a = 1'b0;
        ticks(6);
        chk(torque_shutoff, 1'b0);
        chk(servo_ready, 1'b0);
        alarm_clear = 1'b1;
        ticks(1);
        alarm_clear = 1'b0;
        ticks(3);
        chk(safety_alarm.active, 1'b0);
        chk(servo_ready, 1'b1);
        chk(display_code, torque_shutoff_pkg::DISPLAY_BLANK);
    endtask
    task automatic test_done;
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100us;
        fail_count++;
        test_done();
    end
    initial begin
        {rst_b, open_a, open_b, servo_on_cmd, alarm_clear} = 5'h00;
        stop_seq = 2'h0;
        gate_cmd = 6'h00;
        ticks(5);
        rst_b = 1'b1;
        t_release();
        t_glitch();
        t_stop();
        t_fault();
        test_done();
    end
endmodule // test_safe_torque_off_control
`default_nettype wire
